// [pkg/smtx_map.vh]
`ifndef SMTX_MAP_VH
`define SMTX_MAP_VH
// Command codes
`define SMTX_CMD_BLK_WR 8'hF0
`define SMTX_CMD_BLK_RD 8'hF1
// Implemented register space and limits
`define SMTX_REG_LAST 8'hEF
`define SMTX_ADDR_MAX 8'hFF
`define SMTX_OUT_OF_SPACE 8'h00
// Default own 7-bit address (arbitrary value)
`define SMTX_DEV_ADDR 7'h2C
`endif

// [verilog/smtx_regmem.v]
`timescale 1ns/1ns
`default_nettype none
module smtx_regmem (
	// Clock
	input wire sys_clk,
	// Write port
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	// Read port
	input wire [7:0] rd_addr,
	output reg [7:0] rd_data
);
	reg [7:0] mem [0:239];

	always @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // smtx_regmem
`default_nettype wire

// [verilog/smtx_slave.v]
// Notes on behaviour
// (R1) START, own address, then acknowledge
// (R2) Word write: address, low, high, all acked
// (R3) Command F0h starts coded block write
// (R4) Byte count acked, value ignored
// (R5) First byte after count is start address
// (R6) Long blocks accepted, every byte acked
// (R7) Plain block: first byte is address
// (R8) Every written byte acknowledged
// (R9) Writes beyond space acked, discarded
// (R10) Write address saturates at FFh
// (R11) Read follows address write and restart
// (R12) Byte read returns one byte
// (R13) Word read returns low then high
// (R14) F1h call: count 2, address, read count
// (R15) Call read returns count byte first
// (R16) Host nacks final byte then STOPs
// (R17) Implemented space is 00h to EFh
// (R18) Reads outside space return 00h
// (R19) Base address stays after plain reads
// (R20) Supply bytes while host acknowledges
// (R21) Call data from successive addresses
`timescale 1ns/1ns
`default_nettype none
`include "smtx_map.vh"
module smtx_slave (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Bus clock pin
	input wire scl_in,
	// Bus data pin, open drain
	input wire sda_in,
	output reg sda_out_q,
	output reg sda_oe_n_q
);
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_ADDR = 6'h02;
	localparam [5:0] ST_WRX = 6'h04;
	localparam [5:0] ST_ACK = 6'h08;
	localparam [5:0] ST_TX = 6'h10;
	localparam [5:0] ST_RACK = 6'h20;

	// Write phases within a write transaction
	localparam [6:0] PH_CMD = 7'h01;
	localparam [6:0] PH_DATA = 7'h02;
	localparam [6:0] PH_BCNT = 7'h04;
	localparam [6:0] PH_BADR = 7'h08;
	localparam [6:0] PH_CCNT = 7'h10;
	localparam [6:0] PH_CADR = 7'h20;
	localparam [6:0] PH_CRCNT = 7'h40;

	reg scl_m_q, scl_s_q, scl_p_q;
	reg sda_m_q, sda_s_q, sda_p_q;
	reg [5:0] st_q;
	reg [6:0] ph_q;
	reg [3:0] bit_q;
	reg [7:0] sh_q;
	reg [7:0] base_q;
	reg [7:0] ptr_q;
	reg [7:0] rcnt_q;
	reg call_q;
	reg cnt_first_q;
	reg rd_q;
	reg wr_en_q;
	reg [7:0] wr_addr_q;
	reg [7:0] wr_data_q;
	wire [7:0] mem_rd;
	wire scl_rise = scl_s_q & ~scl_p_q;
	wire scl_fall = ~scl_s_q & scl_p_q;
	wire start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	wire stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	wire [7:0] rx_byte = {sh_q[6:0], sda_s_q};

	function [7:0] sat_inc;
		input [7:0] a;
		begin
			sat_inc = (a == `SMTX_ADDR_MAX) ? a : a + 8'h01; // (R10)
		end
	endfunction

	function in_space;
		input [7:0] a;
		begin
			in_space = (a <= `SMTX_REG_LAST); // (R17)
		end
	endfunction

	smtx_regmem u_mem (
		.sys_clk(sys_clk),
		.wr_en(wr_en_q),
		.wr_addr(wr_addr_q),
		.wr_data(wr_data_q),
		.rd_addr(ptr_q),
		.rd_data(mem_rd)
	);

	// Pins pass two flops; the third stage feeds edge detection
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// Transmit byte: count byte first in a call, else memory or zero
	wire [7:0] tx_byte = cnt_first_q ? rcnt_q :
		(in_space(ptr_q) ? mem_rd : `SMTX_OUT_OF_SPACE); // (R15) (R18)

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			ph_q <= PH_CMD;
			bit_q <= 4'd0;
			sh_q <= 8'h00;
			base_q <= 8'h00;
			ptr_q <= 8'h00;
			rcnt_q <= 8'h00;
			call_q <= 1'b0;
			cnt_first_q <= 1'b0;
			rd_q <= 1'b0;
			wr_en_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
			sda_out_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else begin
			wr_en_q <= 1'b0;
			if (start_c) begin
				// Restart keeps the call context for the read that follows
				st_q <= ST_ADDR; // (R1) (R11)
				bit_q <= 4'h0;
				sda_oe_n_q <= 1'b1;
				sda_out_q <= 1'b1;
			end else if (stop_c) begin
				st_q <= ST_IDLE;
				call_q <= 1'b0;
				sda_oe_n_q <= 1'b1;
				sda_out_q <= 1'b1;
			end else begin
				case (st_q)
				ST_IDLE: begin
					sda_oe_n_q <= 1'b1;
				end
				ST_ADDR, ST_WRX: begin
					if (scl_rise) begin
						sh_q <= rx_byte;
						bit_q <= bit_q + 4'd1;
					end else if (scl_fall && bit_q == 4'd8) begin
						bit_q <= 4'd0;
						if (st_q == ST_ADDR) begin
							rd_q <= sh_q[0];
							if (sh_q[7:1] == `SMTX_DEV_ADDR) begin
								sda_out_q <= 1'b0; // (R1)
								sda_oe_n_q <= 1'b0;
								st_q <= ST_ACK;
								if (sh_q[0]) begin
									ph_q <= PH_CMD;
									// Read: pointer from base; call begins with count
									ptr_q <= base_q; // (R19)
									cnt_first_q <= call_q; // (R15)
									sh_q <= 8'hFF;
								end else begin
									ph_q <= PH_CMD;
									call_q <= 1'b0;
									sh_q <= 8'h00;
								end
							end else begin
								st_q <= ST_IDLE;
							end
						end else begin
							// Every write byte acknowledged, whatever its target
							sda_out_q <= 1'b0; // (R8) (R6) (R9)
							sda_oe_n_q <= 1'b0;
							st_q <= ST_ACK;
							case (ph_q)
							PH_CMD: begin
								if (sh_q == `SMTX_CMD_BLK_WR) begin
									ph_q <= PH_BCNT; // (R3)
								end else if (sh_q == `SMTX_CMD_BLK_RD) begin
									ph_q <= PH_CCNT; // (R14)
									call_q <= 1'b1;
								end else begin
									base_q <= sh_q; // (R7) (R11)
									ptr_q <= sh_q;
									ph_q <= PH_DATA;
								end
							end
							PH_BCNT: begin
								ph_q <= PH_BADR; // (R4)
							end
							PH_BADR: begin
								base_q <= sh_q; // (R5)
								ptr_q <= sh_q;
								ph_q <= PH_DATA;
							end
							PH_CCNT: begin
								ph_q <= PH_CADR; // (R14)
							end
							PH_CADR: begin
								base_q <= sh_q; // (R21)
								ph_q <= PH_CRCNT;
							end
							PH_CRCNT: begin
								rcnt_q <= sh_q; // (R15)
							end
							default: begin
								// Data: store low then high, saturating pointer
								wr_en_q <= in_space(ptr_q); // (R2) (R9)
								wr_addr_q <= ptr_q;
								wr_data_q <= sh_q;
								ptr_q <= sat_inc(ptr_q); // (R10)
							end
							endcase
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rd_q) begin
							// Read address acked: first data bit goes out
							st_q <= ST_TX;
							sda_out_q <= tx_byte[7];
							sda_oe_n_q <= tx_byte[7];
							sh_q <= {tx_byte[6:0], 1'b1};
							bit_q <= 4'h1;
						end else begin
							st_q <= ST_WRX;
							sda_oe_n_q <= 1'b1;
							sda_out_q <= 1'b1;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_q == 4'd8) begin
							sda_oe_n_q <= 1'b1; // Release for host's ack
							sda_out_q <= 1'b1;
							st_q <= ST_RACK;
						end else begin
							sda_out_q <= sh_q[7];
							sda_oe_n_q <= sh_q[7];
							sh_q <= {sh_q[6:0], 1'b1};
							bit_q <= bit_q + 4'd1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						if (sda_s_q) begin
							st_q <= ST_IDLE; // (R12) (R16) (R20)
							// Call read leaves base past the last byte; plain read keeps it
							if (call_q) begin
								base_q <= sat_inc(ptr_q); // (R19)
							end
						end else begin
							// Advance: low then high, successive bytes while acked
							if (cnt_first_q) begin
								cnt_first_q <= 1'b0;
							end else begin
								ptr_q <= sat_inc(ptr_q); // (R13) (R20) (R21)
							end
						end
					end else if (scl_fall) begin
						st_q <= ST_TX;
						sda_out_q <= tx_byte[7];
						sda_oe_n_q <= tx_byte[7];
						sh_q <= {tx_byte[6:0], 1'b1};
						bit_q <= 4'd1;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule // smtx_slave
`default_nettype wire

// [verif/smtx_slave_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module smtx_slave_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out_q,
	input wire logic sda_oe_n_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_start;
		scl_in && $past(scl_in) && $fell(sda_in);
	endsequence
	sequence s_stop;
		scl_in && $past(scl_in) && $rose(sda_in);
	endsequence
	chk_reset_idle: assert property ($rose(rst_n) |-> sda_oe_n_q && sda_out_q)
		else $error("bus held after reset");
	chk_pull_low: assert property (!sda_oe_n_q |-> !sda_out_q)
		else $error("drives high");
	chk_release_high: assert property (sda_oe_n_q |-> sda_out_q)
		else $error("released value low");
	chk_turn_scl_low: assert property ($changed(sda_oe_n_q) |-> !$past(scl_in, 3))
		else $error("turn outside clock low");
	chk_hold_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n_q))
		else $error("enable moved in clock high");
	chk_data_stable: assert property (scl_in && $past(scl_in) |-> $stable(sda_out_q))
		else $error("data moved in clock high");
	chk_start_quiet: assert property (s_start |-> sda_oe_n_q [*8])
		else $error("drives after start");
	chk_stop_quiet: assert property (s_stop |=> sda_oe_n_q [*8])
		else $error("drives after stop");
endmodule // smtx_slave_chk
bind smtx_slave smtx_slave_chk smtx_slave_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q));
`default_nettype wire

// [verif/smtx_host.sv]
`timescale 1ns/1ns
`default_nettype none
module smtx_host (
	// Clock
	input wire logic sys_clk,
	// Bus pins
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Low phase of 5 leaves room for the slave's 3-4 cycle turnaround
	task automatic bit_io(input logic b, output logic r);
		w(1);
		sda_low = !b;
		w(4);
		scl = 1'b1;
		w(2);
		r = sda;
		w(1);
		scl = 1'b0;
	endtask
	task automatic start_c;
		w(1);
		sda_low = 1'b0;
		w(5);
		scl = 1'b1;
		w(3);
		sda_low = 1'b1;
		w(3);
		scl = 1'b0;
	endtask
	task automatic stop_c;
		w(1);
		sda_low = 1'b1;
		w(5);
		scl = 1'b1;
		w(3);
		sda_low = 1'b0;
		w(3);
	endtask
	task automatic byte_tx(input logic [7:0] d, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ak = !r;
	endtask
	task automatic byte_rx(input logic ak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(!ak, r);
	endtask
endmodule // smtx_host
`default_nettype wire

// [verif/smtx_slave_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "smtx_map.vh"
module smtx_slave_test;
	logic sys_clk, rst_n, scl, sda_low, ak, sda_out_q, sda_oe_n_q;
	wire sda_w;
	int miscompares = 0, tests_run = 0;
	logic [7:0] ref_mem [0:255];
	logic [7:0] w[$], rq[$];
	// Open-drain wire with pull-up
	assign sda_w = !(sda_low || (!sda_oe_n_q && !sda_out_q));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	smtx_slave smtx_slave_inst (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl),
		.sda_in(sda_w), .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q));
	smtx_host smtx_host_inst (.sys_clk(sys_clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk_ack(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t ack %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_at(input int p);
		return (p > `SMTX_REG_LAST) ? 8'h00 : ref_mem[p];
	endfunction
	task automatic txn(input int nr);
		logic [7:0] d;
		rq = {};
		if (w.size() > 0) begin
			smtx_host_inst.start_c();
			smtx_host_inst.byte_tx({`SMTX_DEV_ADDR, 1'b0}, ak);
			chk_ack(ak, 1'b1);
			foreach (w[i]) begin
				smtx_host_inst.byte_tx(w[i], ak);
				chk_ack(ak, 1'b1);
			end
		end
		if (nr > 0) begin
			smtx_host_inst.start_c();
			smtx_host_inst.byte_tx({`SMTX_DEV_ADDR, 1'b1}, ak);
			chk_ack(ak, 1'b1);
			for (int i = 0; i < nr; i++) begin
				smtx_host_inst.byte_rx(i < nr - 1, d);
				rq.push_back(d);
			end
		end
		smtx_host_inst.stop_c();
	endtask
	task automatic cmp_from(input int s, input int k);
		for (int i = k; i < rq.size(); i++)
			chk(rq[i], exp_at(s + i - k));
	endtask
	initial begin
		logic [7:0] a, n, d;
		rst_n = 1'b0;
		for (int i = 8'hF0; i <= 8'hFF; i++)
			ref_mem[i] = 8'h00;
		a = 8'($urandom(32'h6528_e697));
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		a = 8'($urandom_range(8'hEE, 0));
		ref_mem[a] = 8'($urandom);
		ref_mem[a + 1] = 8'($urandom);
		w = '{a, ref_mem[a], ref_mem[a + 1]};
		txn(0);
		w = '{a};
		txn(2);
		cmp_from(a, 0);
		w = {};
		txn(1);
		cmp_from(a, 0);
		$display("test word done");
		smtx_host_inst.start_c();
		smtx_host_inst.byte_tx({`SMTX_DEV_ADDR ^ 7'h01, 1'b0}, ak);
		chk_ack(ak, 1'b0);
		smtx_host_inst.stop_c();
		$display("test foreign done");
		// Wrap witness at 00h
		ref_mem[0] = 8'h5A;
		w = '{8'h00, 8'h5A};
		txn(0);
		w = '{`SMTX_CMD_BLK_WR, 8'h03, 8'hE8};
		for (int i = 0; i < 40; i++) begin
			d = 8'($urandom);
			w.push_back(d);
			if (i < 8)
				ref_mem[8'hE8 + i] = d;
		end
		txn(0);
		w = '{`SMTX_CMD_BLK_RD, 8'h02, 8'hE8, 8'h0C};
		txn(14);
		chk(rq[0], 8'h0C);
		cmp_from(8'hE8, 1);
		// Reset in mid-run with the bus idle; register contents must survive it
		rst_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		w = '{8'h00};
		txn(1);
		chk(rq[0], 8'h5A);
		$display("test coded block done");
		repeat (4) begin
			a = 8'($urandom_range(8'hC8, 0));
			n = 8'($urandom_range(6, 1));
			w = '{a};
			for (int i = 0; i <= n; i++) begin
				d = 8'($urandom);
				w.push_back(d);
				ref_mem[a + i] = d;
			end
			txn(0);
			w = '{`SMTX_CMD_BLK_RD, 8'h02, a, n};
			txn(n + 2);
			chk(rq[0], n);
			cmp_from(a, 1);
		end
		$display("test plain block done");
		print_verdict();
	end
	initial begin
		repeat (50000) @(posedge sys_clk);
		miscompares++;
		print_verdict();
	end
endmodule // smtx_slave_test
`default_nettype wire
